// [testbench.sv]
// Bench: host model feeds the decoder; expected codes kept here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
    import vcwd_pkg::*;
    logic clk = 0, resetn = 0, sClk, sData, sEn_n, ld_n, aV;
    logic [6:0] mA, m;
    logic [29:0] cG, c;
    logic [2:0] sD, s;
    int n_fail = 0, check_count = 0;
    // F8: high address bits ignored; 6A: high data bits ignored
    logic [15:0] rows [8] = '{16'hF87F, 16'h8110, 16'h820F, 16'h836A,
        16'h841E, 16'h8500, 16'h8601, 16'h8715};
    always #2 clk = ~clk;
    vcwd_decoder uut (.clk(clk), .resetn(resetn), .serialClk(sClk),
        .serialData(sData), .shiftEnable_n(sEn_n), .load_strobe_n(ld_n),
        .masterAtten(mA), .chanGain(cG), .selectedDac(sD), .addrValid(aV));
    vcwd_host host (.sClk(sClk), .sData(sData), .sEn_n(sEn_n), .ld_n(ld_n));
    task test_done;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    initial begin
        m = MASTER_RESET;
        c = {NUM_CHAN{CHAN_RESET}};
        repeat (5) @(posedge clk);
        #1 resetn = 1;
        foreach (rows[i]) begin
            s = rows[i][10:8];
            host.send(rows[i][15:8]);
            host.send(rows[i][7:0]);
            if (s == SEL_MASTER) m = rows[i][6:0];
            else if (s != SEL_NONE) c[5 * (s - 1) +: 5] = rows[i][4:0];
            `CHK("codes", {m, c, s}, {mA, cG, sD})
            $display("row %0d done", i);
        end
        s = 3'h4;
        host.send(8'h84);
        host.send_split(8'h05);
        c[5 * (s - 1) +: 5] = 5'h05;
        `CHK("split", {m, c, s}, {mA, cG, sD})
        host.send(8'h12);
        c[5 * (s - 1) +: 5] = 5'h12;
        `CHK("repeat", {m, c, s}, {mA, cG, sD})
        $display("split and repeat done");
        @(posedge clk);
        #1 resetn = 0;
        repeat (5) @(posedge clk);
        #1 resetn = 1;
        m = MASTER_RESET;
        c = {NUM_CHAN{CHAN_RESET}};
        @(posedge clk);
        #1 `CHK("reset", {m, c, SEL_NONE, 1'b0}, {mA, cG, sD, aV})
        host.send(8'h05);
        `CHK("orphan", {m, c, SEL_NONE, 1'b0}, {mA, cG, sD, aV})
        $display("reset and orphan done");
        test_done();
    end
endmodule : testbench

// [vcwd_decoder.sv]
// Serial control word decoder: shift register, holding register, DAC settings.
// Assumes serial pins are asynchronous to clk and far slower (at least 4 clk per half period).
`timescale 1ns/1ps

// Notes on behaviour
// - The master code is an attenuation common to all channels, 0 down to -127 dB in 1 dB steps.
// - Each channel code adds gain to its own channel only, 0 to 31 dB in 1 dB steps.
// - Codes run inverse to level: master 7F is 0 dB, channel 00 is +31 dB and 1F is 0 dB.
// - The low three address bits pick master, channel one to six, or nothing for 111.
// - The master setting scales all six channels ahead of each channel's own gain.
// - An update is an address byte with MSB high followed by a data byte with MSB low.
// - While shift enable is low, data enters MSB first on each falling serial clock edge.
// - The holding register loads only on the rising edge of the load strobe.
module vcwd_decoder (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic shiftEnable_n,
    input wire logic load_strobe_n,
    output logic [vcwd_pkg::MASTER_BITS-1:0] masterAtten,
    output logic [vcwd_pkg::NUM_CHAN*vcwd_pkg::CHAN_BITS-1:0] chanGain,
    output logic [vcwd_pkg::SEL_BITS-1:0] selectedDac,
    output logic addrValid
);
    import vcwd_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // All four pins idle high, so the flops reset high and no
    // false edge appears when reset lifts.
    logic [3:0] pinRaw;
    logic [3:0] pinSync;
    logic sclkS;
    logic dataS;
    logic wrnS;
    logic ldnS;

    assign pinRaw = {serialClk, serialData, shiftEnable_n, load_strobe_n};

    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : gPin
            vcwd_sync2 #(
                .RESET_VAL(PIN_IDLE)
            ) uSync (
                .clk(clk),
                .resetn(resetn),
                .pinIn(pinRaw[gp]),
                .pinOut(pinSync[gp])
            );
        end
    endgenerate

    assign sclkS = pinSync[3];
    assign dataS = pinSync[2];
    assign wrnS = pinSync[1];
    assign ldnS = pinSync[0];

    // ==========================================================
    // Edge detectors
    // Clock and strobe share the same sync depth, so the last shift
    // always lands before the strobe edge is seen.
    logic sclkFall;
    logic ldRise;

    vcwd_edge_detect #(
        .IDLE(PIN_IDLE)
    ) uSclkEdge (
        .clk(clk),
        .resetn(resetn),
        .level(sclkS),
        .rise(),
        .fall(sclkFall)
    );

    vcwd_edge_detect #(
        .IDLE(PIN_IDLE)
    ) uLoadEdge (
        .clk(clk),
        .resetn(resetn),
        .level(ldnS),
        .rise(ldRise),
        .fall()
    );

    // ==========================================================
    // Shift register
    // No bit counter: only the last eight bits before the strobe count.
    logic [BYTE_BITS-1:0] shift_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_q <= '0;
        end else if (sclkFall && !wrnS) begin
            shift_q <= {shift_q[BYTE_BITS-2:0], dataS};
        end
    end

    // ==========================================================
    // Byte phase
    // MSB of the latched byte tells address from data.
    typedef enum logic [1:0] {
        PH_NO_ADDR = 2'h1,
        PH_ADDR_HELD = 2'h2
    } vcwd_phase_e;

    vcwd_phase_e phase_q;
    logic addrLoad;
    logic dataLoad;

    assign addrLoad = ldRise && shift_q[BYTE_BITS-1];
    assign dataLoad = ldRise && !shift_q[BYTE_BITS-1]
                      && (phase_q == PH_ADDR_HELD);

    // Address persists so several data bytes may follow one address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase_q <= PH_NO_ADDR;
        end else begin
            unique case (phase_q)
                PH_NO_ADDR: begin
                    if (addrLoad) begin
                        phase_q <= PH_ADDR_HELD;
                    end
                end
                PH_ADDR_HELD: begin
                    phase_q <= PH_ADDR_HELD;
                end
                default: begin
                    phase_q <= PH_NO_ADDR;
                end
            endcase
        end
    end

    logic [SEL_BITS-1:0] sel_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_q <= SEL_NONE;
        end else if (addrLoad) begin
            sel_q <= shift_q[SEL_BITS-1:0];
        end
    end

    // ==========================================================
    // DAC code registers
    // Codes are kept as written; the analog side reads them inverted.
    logic masterWe;
    logic [NUM_CHAN-1:0] chanWe;
    logic [MASTER_BITS-1:0] masterCode;
    logic [CHAN_BITS-1:0] chanCode [NUM_CHAN];

    assign masterWe = dataLoad && (sel_q == SEL_MASTER);

    vcwd_code_reg #(
        .WIDTH(MASTER_BITS),
        .RESET_VAL(MASTER_RESET)
    ) uMaster (
        .clk(clk),
        .resetn(resetn),
        .load(masterWe),
        .codeIn(shift_q[MASTER_BITS-1:0]),
        .code(masterCode)
    );

    // Select codes 1..6 map to channels 0..5; code 7 matches none
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : gChan
            assign chanWe[gi] = dataLoad && (sel_q == SEL_BITS'(gi + 1));

            vcwd_code_reg #(
                .WIDTH(CHAN_BITS),
                .RESET_VAL(CHAN_RESET)
            ) uChan (
                .clk(clk),
                .resetn(resetn),
                .load(chanWe[gi]),
                .codeIn(shift_q[CHAN_BITS-1:0]),
                .code(chanCode[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Outputs
    // One master code feeds every channel's summing node.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            masterAtten <= MASTER_RESET;
            chanGain <= {NUM_CHAN{CHAN_RESET}};
            selectedDac <= SEL_NONE;
            addrValid <= 1'b0;
        end else begin
            masterAtten <= masterCode;
            for (int i = 0; i < NUM_CHAN; i++) begin
                chanGain[i*CHAN_BITS +: CHAN_BITS] <= chanCode[i];
            end
            selectedDac <= sel_q;
            addrValid <= (phase_q == PH_ADDR_HELD);
        end
    end
endmodule : vcwd_decoder

// ==========================================================
// Two-flop synchroniser for one pin
module vcwd_sync2 #(
    parameter logic RESET_VAL = 1'h1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pinIn,
    output logic pinOut
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q <= RESET_VAL;
            pinOut <= RESET_VAL;
        end else begin
            meta_q <= pinIn;
            pinOut <= meta_q;
        end
    end
endmodule : vcwd_sync2

// ==========================================================
// Edge detector on a synchronised level
module vcwd_edge_detect #(
    parameter logic IDLE = 1'h1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prev_q <= IDLE;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = !prev_q && level;
    assign fall = prev_q && !level;
endmodule : vcwd_edge_detect

// ==========================================================
// Loadable code register for one DAC
module vcwd_code_reg #(
    parameter int unsigned WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] codeIn,
    output logic [WIDTH-1:0] code
);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code <= RESET_VAL;
        end else if (load) begin
            code <= codeIn;
        end
    end
endmodule : vcwd_code_reg

// [vcwd_decoder_properties.sv]
// Port checker for vcwd_decoder, bound below.
// Assumes the decoder's ports only, one clock domain on clk.
`timescale 1ns/1ps
module vcwd_decoder_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic shiftEnable_n,
    input wire logic load_strobe_n,
    input wire logic [6:0] masterAtten,
    input wire logic [29:0] chanGain,
    input wire logic [2:0] selectedDac,
    input wire logic addrValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RST: assert property ($rose(resetn) |-> masterAtten == 7'h00 && !addrValid
        && chanGain == {6{5'h1F}} && selectedDac == 3'h7) else $error("reset");
    AST_HOLD: assert property (load_strobe_n [*7] |->
        $stable({masterAtten, chanGain, selectedDac})) else $error("hold");
    AST_LAT: assert property ($changed(selectedDac) |->
        load_strobe_n && !$past(load_strobe_n, 7)) else $error("latency");
    AST_ADDR: assert property ($changed(selectedDac) |-> addrValid) else $error("addr");
    AST_NOSEL: assert property (selectedDac == 3'h7 && $past(selectedDac) == 3'h7
        |-> $stable({masterAtten, chanGain})) else $error("none");
    AST_MONLY: assert property (selectedDac == 3'h0 && $stable(selectedDac)
        |-> $stable(chanGain)) else $error("master");
    AST_CONLY: assert property (selectedDac != 3'h0 && $stable(selectedDac)
        |-> $stable(masterAtten)) else $error("chan");
    AST_ONE: assert property ($changed(chanGain) |-> ((chanGain ^ $past(chanGain))
        & ~(30'h1F << 5 * (selectedDac - 1))) == 0) else $error("field");
    cover property ($changed(masterAtten));
    cover property ($changed(chanGain));
    cover property (selectedDac == 3'h7 && addrValid);
endmodule : vcwd_decoder_checker
bind vcwd_decoder vcwd_decoder_checker chk (
    .clk(clk),
    .resetn(resetn),
    .serialClk(serialClk),
    .serialData(serialData),
    .shiftEnable_n(shiftEnable_n),
    .load_strobe_n(load_strobe_n),
    .masterAtten(masterAtten),
    .chanGain(chanGain),
    .selectedDac(selectedDac),
    .addrValid(addrValid)
);

// [vcwd_host.sv]
// Host model: 3-wire send with load strobe tied to shift enable, plus a 4-wire split send.
`timescale 1ns/1ps
module vcwd_host (
    output logic sClk,
    output logic sData,
    output logic sEn_n,
    output logic ld_n
);
    initial {sClk, sData, sEn_n, ld_n} = 4'hF;
    task automatic send(input logic [7:0] b);
        {sEn_n, ld_n} = 2'b00;
        for (int i = 7; i >= 0; i--) begin
            sData = b[i];
            #16 sClk = 0;
            #16 sClk = 1;
        end
        #16 {sEn_n, ld_n} = 2'b11;
        sData = ~sData; // No stale bit once released
        #200;
    endtask : send
    // 4-wire: strobe rises after the enable, clocks in between ignored
    task automatic send_split(input logic [7:0] b);
        {sEn_n, ld_n} = 2'b00;
        for (int i = 7; i >= 0; i--) begin
            sData = b[i];
            #16 sClk = 0;
            #16 sClk = 1;
        end
        #16 sEn_n = 1'b1;
        sData = ~sData;
        repeat (2) begin
            #16 sClk = 0;
            #16 sClk = 1;
        end
        #16 ld_n = 1'b1;
        #200;
    endtask : send_split
endmodule : vcwd_host

// [vcwd_pkg.sv]
// Constants for the serial volume control word decoder.
// Assumes a single system clock domain that samples the serial pins.
package vcwd_pkg;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned MASTER_BITS = 7;
    localparam int unsigned CHAN_BITS = 5;
    localparam int unsigned NUM_CHAN = 6;
    localparam int unsigned SEL_BITS = 3;
    localparam logic [SEL_BITS-1:0] SEL_MASTER = 3'h0;
    localparam logic [SEL_BITS-1:0] SEL_NONE = 3'h7;
    // Reset values: full attenuation, least channel gain
    localparam logic [MASTER_BITS-1:0] MASTER_RESET = 7'h00;
    localparam logic [CHAN_BITS-1:0] CHAN_RESET = 5'h1F;
    localparam logic [CHAN_BITS-1:0] CHAN_CENTRE = 5'h10;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    // Idle level of every serial pin, also the synchroniser reset value
    localparam logic PIN_IDLE = 1'h1;
endpackage : vcwd_pkg
